// ---- common/cfes_pkg.sv ----
package cfes_pkg;

  // machine cycle timing
  localparam int unsigned OSC_PER_STATE   = 2;
  localparam int unsigned STATES_PER_CYC  = 6;
  localparam int unsigned OSC_PER_CYC     = OSC_PER_STATE * STATES_PER_CYC;
  localparam logic [3:0]  TICK_FIRST      = 4'h0;
  localparam logic [3:0]  TICK_SLOT_A_DAT = 4'h1;
  localparam logic [3:0]  TICK_PRE_B      = 4'h5;
  localparam logic [3:0]  TICK_SLOT_B_DAT = 4'h7;
  localparam logic [3:0]  TICK_LAST       = 4'(OSC_PER_CYC - 1);

  // special-function register addresses and reset values
  localparam logic [7:0]  SFR_ACC    = 8'hE0;
  localparam logic [7:0]  SFR_AUX    = 8'hF0;
  localparam logic [7:0]  SFR_SP     = 8'h81;
  localparam logic [7:0]  SFR_WPL    = 8'h82;
  localparam logic [7:0]  SFR_WPH    = 8'h83;
  localparam logic [7:0]  SFR_PSW    = 8'hD0;
  localparam logic [7:0]  AUX_RST    = 8'h00;
  localparam logic [7:0]  SP_RST     = 8'h07;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  PSW_RST    = 8'h00;
  localparam logic [15:0] WPTR_RST   = 16'h0000;
  localparam logic [15:0] PC_RST     = 16'h0000;
  localparam int unsigned PSW_BANK_HI = 4;
  localparam int unsigned PSW_BANK_LO = 3;
  localparam logic [7:0]  BIT_RAM_BASE = 8'h20;
  localparam logic [7:0]  XMEM_PAGE_HI = 8'h00;

  // opcodes
  localparam logic [4:0] OPL_PAGE_JUMP = 5'h01;
  localparam logic [4:0] OPH_DECREMENT_BRANCH_NONZERO_REG  = 5'h1B;
  localparam logic [7:0] OP_NOP        = 8'h00;
  localparam logic [7:0] OP_LONG_JUMP  = 8'h02;
  localparam logic [7:0] OP_BIT_CLR    = 8'h10;
  localparam logic [7:0] OP_ACC_ZERO   = 8'h60;
  localparam logic [7:0] OP_ACC_NZ     = 8'h70;
  localparam logic [7:0] OP_A_IMM      = 8'h74;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_WPTR_LOAD  = 8'h90;
  localparam logic [7:0] OP_PUSH       = 8'hC0;
  localparam logic [7:0] OP_POP        = 8'hD0;
  localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_DIR   = 8'hD5;
  localparam logic [7:0] OP_XRD_WPTR   = 8'hE0;
  localparam logic [7:0] OP_XRD_R0     = 8'hE2;
  localparam logic [7:0] OP_XRD_R1     = 8'hE3;
  localparam logic [7:0] OP_A_DIR      = 8'hE5;
  localparam logic [7:0] OP_A_IND0     = 8'hE6;
  localparam logic [7:0] OP_A_IND1     = 8'hE7;
  localparam logic [7:0] OP_XWR_WPTR   = 8'hF0;
  localparam logic [7:0] OP_XWR_R0     = 8'hF2;
  localparam logic [7:0] OP_XWR_R1     = 8'hF3;
  localparam logic [7:0] OP_DIR_A      = 8'hF5;
  localparam logic [7:0] OP_IND0_A     = 8'hF6;
  localparam logic [7:0] OP_IND1_A     = 8'hF7;

  typedef enum logic [4:0] {
    CL_NOP = 5'b00000, CL_PAGE_JUMP = 5'b00001, CL_LONG_JUMP = 5'b00010,
    CL_BIT_CLR = 5'b00011, CL_ACC_ZERO = 5'b00100, CL_ACC_NZ = 5'b00101,
    CL_SHORT_JUMP = 5'b00110, CL_WPTR_LOAD = 5'b00111, CL_PUSH = 5'b01000,
    CL_POP = 5'b01001, CL_DECREMENT_BRANCH_NONZERO_DIR = 5'b01010, CL_DECREMENT_BRANCH_NONZERO_REG = 5'b01011,
    CL_A_DIR = 5'b01100, CL_DIR_A = 5'b01101, CL_A_IMM = 5'b01110,
    CL_XREAD = 5'b01111, CL_XWRITE = 5'b10000, CL_A_IND = 5'b10001,
    CL_IND_A = 5'b10010
  } cfes_class_type;

  typedef enum logic [0:0] {
    SEQ_FIRST  = 1'b0,
    SEQ_SECOND = 1'b1
  } cfes_seq_type;

  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } cfes_code_req_type;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cfes_xmem_req_type;

  localparam cfes_code_req_type CODE_RST = '{rd: 1'b1, addr: PC_RST};

endpackage : cfes_pkg

// ---- rtl/cfes_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RL1: direct operand address is an 8-bit field; 80h-FFh reaches only special registers
// RL2: 8-bit indirect address comes from working reg 0/1 of bank, or stack pointer
// RL3: 16-bit indirect address comes only from the wide pointer register
// RL4: external data uses indirect address only: working reg 0/1 or wide pointer
// RL5: accumulator is source of external writes and destination of external reads
// RL6: bit test-clear jump branches when bit is one and clears that bit
// RL7: taken relative jump adds signed offset byte to program counter
// RL8: relative target is -128..+127 from first byte after the jump
// RL9: three unconditional jump encodings differ only in destination format
// RL10: short relative jump is two bytes: opcode plus offset
// RL11: machine cycle is six states of two oscillator periods, twelve in all
// RL12: each state has phase one and phase two halves for fetch and execute
// RL13: two fetches per cycle; unneeded byte discarded and counter not advanced
// RL14: opcode latched in state one, second fetch in state four, done end state six
// RL15: external move takes two cycles, no fetch in second; only fetch skip
// RL16: decrement-branch decrements direct or register operand, jumps when not zero
// RL17: long jump has 16-bit target; page jump replaces low 11 bits of counter
// RL18: accumulator zero/nonzero jumps test whole accumulator, relative offset
module cfes_sequencer (
  // clock, reset, enable
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        ce,
  // program memory
  output var  cfes_pkg::cfes_code_req_type code_req,
  input  wire logic [7:0]                  code_data,
  // external data memory
  output var  cfes_pkg::cfes_xmem_req_type xmem_req,
  input  wire logic [7:0]                  xmem_rdata,
  // observation
  output var  logic [15:0]                 pc_out,
  output var  logic [7:0]                  acc_out,
  output var  logic [2:0]                  state_num,
  output var  logic                        phase_two,
  output var  logic                        instr_done
);
  import cfes_pkg::*;

  function automatic cfes_class_type classify(input logic [7:0] op);
    classify = CL_NOP;
    if (op[4:0] == OPL_PAGE_JUMP) begin
      classify = CL_PAGE_JUMP;
    end else if (op[7:3] == OPH_DECREMENT_BRANCH_NONZERO_REG) begin
      classify = CL_DECREMENT_BRANCH_NONZERO_REG;
    end else begin
      case (op)
        OP_LONG_JUMP:                       classify = CL_LONG_JUMP;
        OP_BIT_CLR:                         classify = CL_BIT_CLR;
        OP_ACC_ZERO:                        classify = CL_ACC_ZERO;
        OP_ACC_NZ:                          classify = CL_ACC_NZ;
        OP_A_IMM:                           classify = CL_A_IMM;
        OP_SHORT_JUMP:                      classify = CL_SHORT_JUMP;
        OP_WPTR_LOAD:                       classify = CL_WPTR_LOAD;
        OP_PUSH:                            classify = CL_PUSH;
        OP_POP:                             classify = CL_POP;
        OP_DECREMENT_BRANCH_NONZERO_DIR:                        classify = CL_DECREMENT_BRANCH_NONZERO_DIR;
        OP_XRD_WPTR, OP_XRD_R0, OP_XRD_R1:  classify = CL_XREAD;
        OP_XWR_WPTR, OP_XWR_R0, OP_XWR_R1:  classify = CL_XWRITE;
        OP_A_DIR:                           classify = CL_A_DIR;
        OP_DIR_A:                           classify = CL_DIR_A;
        OP_A_IND0, OP_A_IND1:               classify = CL_A_IND;
        OP_IND0_A, OP_IND1_A:               classify = CL_IND_A;
        default:                            classify = CL_NOP;
      endcase
    end
  endfunction : classify

  function automatic logic [1:0] instr_len(input cfes_class_type cl);
    case (cl)
      CL_LONG_JUMP, CL_BIT_CLR, CL_WPTR_LOAD, CL_DECREMENT_BRANCH_NONZERO_DIR: instr_len = 2'd3;
      CL_NOP, CL_XREAD, CL_XWRITE, CL_A_IND, CL_IND_A:     instr_len = 2'd1;
      default:                                             instr_len = 2'd2;
    endcase
  endfunction : instr_len

  function automatic logic two_cycle(input cfes_class_type cl);
    case (cl)
      CL_NOP, CL_A_DIR, CL_DIR_A, CL_A_IMM, CL_A_IND, CL_IND_A: two_cycle = 1'b0;
      default:                                                 two_cycle = 1'b1;
    endcase
  endfunction : two_cycle

  // working register location in the selected bank
  function automatic logic [7:0] reg_loc(input logic [7:0] psw, input logic [2:0] idx);
    reg_loc = {3'b000, psw[PSW_BANK_HI:PSW_BANK_LO], idx};
  endfunction : reg_loc

  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] acc,
                                          input logic [7:0] aux, input logic [7:0] sp,
                                          input logic [7:0] psw, input logic [15:0] wp);
    case (a)
      SFR_ACC: sfr_read = acc;
      SFR_AUX: sfr_read = aux;
      SFR_SP:  sfr_read = sp;
      SFR_PSW: sfr_read = psw;
      SFR_WPL: sfr_read = wp[7:0];
      SFR_WPH: sfr_read = wp[15:8];
      default: sfr_read = 8'h00;
    endcase
  endfunction : sfr_read

  logic [3:0]        tick_r, tick_nxt;
  cfes_seq_type      seq_r, seq_nxt;
  logic [15:0]       pc_r, pc_nxt;
  logic [7:0]        ir_r, ir_nxt;
  logic [7:0]        op1_r, op1_nxt;
  logic [7:0]        op2_r, op2_nxt;
  logic [7:0]        acc_r, acc_nxt;
  logic [7:0]        aux_r, aux_nxt;
  logic [7:0]        sp_r, sp_nxt;
  logic [7:0]        psw_r, psw_nxt;
  logic [15:0]       wptr_r, wptr_nxt;
  cfes_code_req_type code_r, code_nxt;
  cfes_xmem_req_type xmem_r, xmem_nxt;
  logic              done_r, done_nxt;
  logic [7:0]        ram [0:255];
  logic              ram_we;
  logic [7:0]        ram_waddr;
  logic [7:0]        ram_wdata;
  cfes_class_type    cls;
  logic [7:0]        ri_ptr;
  logic [7:0]        rd_addr;
  logic              rd_sfr;
  logic [7:0]        operand;
  logic [7:0]        rel;
  logic [15:0]       rel_target;
  logic              wr_en;
  logic              wr_sfr;
  logic [7:0]        wr_addr;
  logic [7:0]        wr_data;
  logic [7:0]        dec_val;

  assign cls        = classify(ir_r);
  assign ri_ptr     = ram[reg_loc(psw_r, {2'b00, ir_r[0]})]; // RL2 RL4
  assign rel        = (cls == CL_BIT_CLR || cls == CL_DECREMENT_BRANCH_NONZERO_DIR) ? op2_r : op1_r;
  // pc already points past the instruction, giving the -128..+127 window
  assign rel_target = pc_r + {{8{rel[7]}}, rel}; // RL7 RL8
  assign dec_val    = operand - 8'h01;

  // operand fetch path
  always_comb begin
    rd_addr = op1_r;
    rd_sfr  = 1'b0;
    case (cls)
      CL_A_DIR, CL_DECREMENT_BRANCH_NONZERO_DIR, CL_PUSH: begin
        rd_addr = op1_r;
        rd_sfr  = op1_r[7]; // RL1
      end
      CL_DECREMENT_BRANCH_NONZERO_REG: rd_addr = reg_loc(psw_r, ir_r[2:0]); // RL16
      CL_A_IND:    rd_addr = ri_ptr; // RL2
      CL_POP:      rd_addr = sp_r; // RL2
      CL_BIT_CLR: begin
        rd_sfr  = op1_r[7];
        rd_addr = op1_r[7] ? {op1_r[7:3], 3'b000} : 8'(BIT_RAM_BASE + {4'h0, op1_r[6:3]});
      end
      default: rd_addr = op1_r;
    endcase
    operand = rd_sfr ? sfr_read(rd_addr, acc_r, aux_r, sp_r, psw_r, wptr_r) : ram[rd_addr];
  end

  // sequencing and execution
  always_comb begin
    tick_nxt  = tick_r;
    seq_nxt   = seq_r;
    pc_nxt    = pc_r;
    ir_nxt    = ir_r;
    op1_nxt   = op1_r;
    op2_nxt   = op2_r;
    acc_nxt   = acc_r;
    aux_nxt   = aux_r;
    sp_nxt    = sp_r;
    psw_nxt   = psw_r;
    wptr_nxt  = wptr_r;
    code_nxt  = code_r;
    xmem_nxt  = xmem_r;
    done_nxt  = done_r;
    wr_en     = 1'b0;
    wr_sfr    = 1'b0;
    wr_addr   = op1_r;
    wr_data   = acc_r;
    ram_we    = 1'b0;
    ram_waddr = op1_r;
    ram_wdata = acc_r;
    if (ce) begin
      tick_nxt    = (tick_r == TICK_LAST) ? TICK_FIRST : 4'(tick_r + 4'h1); // RL11 RL12
      code_nxt.rd = 1'b0;
      xmem_nxt.rd = 1'b0;
      xmem_nxt.wr = 1'b0;
      done_nxt    = 1'b0;
      case (tick_r)
        TICK_SLOT_A_DAT: begin
          if (seq_r == SEQ_FIRST) begin
            ir_nxt = code_data; // RL14
            pc_nxt = pc_r + 16'h0001;
          end else if (cls == CL_XREAD) begin
            acc_nxt = acc_r;
            op2_nxt = xmem_rdata; // RL5
          end else if (instr_len(cls) == 2'd3) begin
            op2_nxt = code_data;
            pc_nxt  = pc_r + 16'h0001; // RL13
          end
        end
        TICK_PRE_B: begin
          // second fetch falls in state four except in the second cycle of an external move
          code_nxt.rd   = !(seq_r == SEQ_SECOND && (cls == CL_XREAD || cls == CL_XWRITE)); // RL14 RL15
          code_nxt.addr = pc_r;
        end
        TICK_SLOT_B_DAT: begin
          if (seq_r == SEQ_FIRST && instr_len(cls) != 2'd1) begin
            op1_nxt = code_data;
            pc_nxt  = pc_r + 16'h0001; // RL13
          end
        end
        TICK_LAST: begin
          if (seq_r == SEQ_FIRST && two_cycle(cls)) begin
            seq_nxt       = SEQ_SECOND;
            code_nxt.rd   = !(cls == CL_XREAD || cls == CL_XWRITE); // RL15
            code_nxt.addr = pc_r;
            xmem_nxt.rd   = (cls == CL_XREAD);
            xmem_nxt.wr   = (cls == CL_XWRITE); // RL5
            xmem_nxt.addr = ir_r[1] ? {XMEM_PAGE_HI, ri_ptr} : wptr_r; // RL3 RL4
            xmem_nxt.wdata = acc_r; // RL5
          end else begin
            seq_nxt  = SEQ_FIRST;
            done_nxt = 1'b1; // RL14
            case (cls)
              CL_PAGE_JUMP:  pc_nxt = {pc_r[15:11], ir_r[7:5], op1_r}; // RL9 RL17
              CL_LONG_JUMP:  pc_nxt = {op1_r, op2_r}; // RL9 RL17
              CL_SHORT_JUMP: pc_nxt = rel_target; // RL9 RL10
              CL_ACC_ZERO:   if (acc_r == 8'h00) pc_nxt = rel_target; // RL18
              CL_ACC_NZ:     if (acc_r != 8'h00) pc_nxt = rel_target; // RL18
              CL_BIT_CLR: begin
                if (operand[op1_r[2:0]]) begin
                  wr_en   = 1'b1; // RL6
                  wr_sfr  = rd_sfr;
                  wr_addr = rd_addr;
                  wr_data = operand & ~(8'h01 << op1_r[2:0]);
                  pc_nxt  = rel_target;
                end
              end
              CL_DECREMENT_BRANCH_NONZERO_DIR, CL_DECREMENT_BRANCH_NONZERO_REG: begin
                wr_en   = 1'b1; // RL16
                wr_sfr  = rd_sfr;
                wr_addr = rd_addr;
                wr_data = dec_val;
                if (dec_val != 8'h00) pc_nxt = rel_target;
              end
              CL_WPTR_LOAD: wptr_nxt = {op1_r, op2_r}; // RL3
              CL_PUSH: begin
                sp_nxt  = sp_r + 8'h01; // RL2
                wr_en   = 1'b1;
                wr_addr = sp_r + 8'h01;
                wr_data = operand;
              end
              CL_POP: begin
                sp_nxt  = sp_r - 8'h01; // RL2
                wr_en   = 1'b1;
                wr_sfr  = op1_r[7];
                wr_data = operand;
              end
              CL_A_DIR, CL_A_IND: acc_nxt = operand; // RL1 RL2
              CL_A_IMM:           acc_nxt = op1_r;
              CL_DIR_A: begin
                wr_en  = 1'b1; // RL1
                wr_sfr = op1_r[7];
              end
              CL_IND_A: begin
                wr_en   = 1'b1; // RL2
                wr_addr = ri_ptr;
              end
              CL_XREAD: acc_nxt = op2_r; // RL5
              default:  pc_nxt = pc_r;
            endcase
            code_nxt.rd   = 1'b1;
            code_nxt.addr = pc_nxt;
          end
        end
        default: code_nxt.rd = 1'b0;
      endcase
      if (wr_en && wr_sfr) begin
        case (wr_addr)
          SFR_ACC: acc_nxt = wr_data;
          SFR_AUX: aux_nxt = wr_data;
          SFR_SP:  sp_nxt  = wr_data;
          SFR_PSW: psw_nxt = wr_data;
          SFR_WPL: wptr_nxt[7:0]  = wr_data;
          SFR_WPH: wptr_nxt[15:8] = wr_data;
          default: acc_nxt = acc_nxt;
        endcase
      end else if (wr_en) begin
        ram_we    = 1'b1;
        ram_waddr = wr_addr;
        ram_wdata = wr_data;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= TICK_FIRST;
      seq_r  <= SEQ_FIRST;
      pc_r   <= PC_RST;
      ir_r   <= OP_NOP;
      op1_r  <= 8'h00;
      op2_r  <= 8'h00;
      acc_r  <= ACC_RST;
      aux_r  <= AUX_RST;
      sp_r   <= SP_RST;
      psw_r  <= PSW_RST;
      wptr_r <= WPTR_RST;
      code_r <= CODE_RST;
      xmem_r <= '0;
      done_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      seq_r  <= seq_nxt;
      pc_r   <= pc_nxt;
      ir_r   <= ir_nxt;
      op1_r  <= op1_nxt;
      op2_r  <= op2_nxt;
      acc_r  <= acc_nxt;
      aux_r  <= aux_nxt;
      sp_r   <= sp_nxt;
      psw_r  <= psw_nxt;
      wptr_r <= wptr_nxt;
      code_r <= code_nxt;
      xmem_r <= xmem_nxt;
      done_r <= done_nxt;
    end
  end

  // data ram holds no reset; contents are undefined until written
  always_ff @(posedge clock) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
    end
  end

  assign code_req   = code_r;
  assign xmem_req   = xmem_r;
  assign pc_out     = pc_r;
  assign acc_out    = acc_r;
  assign state_num  = 3'(tick_r[3:1]) + 3'd1; // RL11
  assign phase_two  = tick_r[0]; // RL12
  assign instr_done = done_r;

endmodule : cfes_sequencer

`default_nettype wire

// ---- testbench/cfes_sequencer_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module cfes_sequencer_asserts (
  // clock and reset
  input wire logic                        clock,
  input wire logic                        rst_n,
  input wire logic                        ce,
  // memories
  input wire cfes_pkg::cfes_code_req_type code_req,
  input wire logic [7:0]                  code_data,
  input wire cfes_pkg::cfes_xmem_req_type xmem_req,
  input wire logic [7:0]                  xmem_rdata,
  // observation
  input wire logic [15:0]                 pc_out,
  input wire logic [7:0]                  acc_out,
  input wire logic [2:0]                  state_num,
  input wire logic                        phase_two,
  input wire logic                        instr_done
);
  import cfes_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // the release edge itself still holds the sequencer, so it starts no attempt
  phase_toggle_a: assert property (ce && rst_n |=> phase_two != $past(phase_two))
    else $error("phase half did not alternate");
  state_step_a: assert property (ce && phase_two |=>
    state_num == (($past(state_num) == 3'h6) ? 3'h1 : $past(state_num) + 3'h1))
    else $error("state did not step after phase two");
  enable_freeze_a: assert property (!ce |=> $stable(state_num) && $stable(pc_out) && $stable(acc_out))
    else $error("state moved while enable low");
  fetch_slot_a: assert property (code_req.rd |-> !phase_two && (state_num == 3'h1 || state_num == 3'h4))
    else $error("program fetch outside state one or four");
  fetch_due_a: assert property (ce && !phase_two && state_num == 3'h1 && !(xmem_req.rd || xmem_req.wr)
    |-> code_req.rd)
    else $error("program fetch missing at state one");
  move_nofetch_a: assert property (ce && (xmem_req.rd || xmem_req.wr) |-> !code_req.rd ##6 !code_req.rd)
    else $error("program fetch during external move cycle");
  move_slot_a: assert property ((xmem_req.rd || xmem_req.wr) |-> state_num == 3'h1 && !phase_two)
    else $error("external strobe outside state one");
  write_acc_a: assert property (xmem_req.wr |-> xmem_req.wdata == acc_out)
    else $error("external write data is not the accumulator");
  read_acc_a: assert property (ce && xmem_req.rd |-> ##12 acc_out == $past(xmem_rdata, 12))
    else $error("external read data did not reach the accumulator");
  done_slot_a: assert property (instr_done |-> state_num == 3'h1 && !phase_two)
    else $error("completion pulse outside state one");
endmodule : cfes_sequencer_asserts

bind cfes_sequencer cfes_sequencer_asserts chk_u (
  .clock(clock), .rst_n(rst_n), .ce(ce), .code_req(code_req), .code_data(code_data),
  .xmem_req(xmem_req), .xmem_rdata(xmem_rdata), .pc_out(pc_out), .acc_out(acc_out),
  .state_num(state_num), .phase_two(phase_two), .instr_done(instr_done)
);
`default_nettype wire

// ---- testbench/cfes_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module cfes_mem_model (
  // clock
  input  wire logic                        clock,
  // program memory
  input  wire cfes_pkg::cfes_code_req_type code_req,
  output logic [7:0]                       code_data,
  // external data memory
  input  wire cfes_pkg::cfes_xmem_req_type xmem_req,
  output logic [7:0]                       xmem_rdata
);
  import cfes_pkg::*;
  logic [7:0] rom  [0:65535];
  logic [7:0] xram [0:65535];

  // erased flash reads as no-op; blank data reads ff so a missed write shows
  initial begin
    for (int i = 0; i < $size(rom); i++) begin
      rom[i]  = 8'h00;
      xram[i] = 8'hff;
    end
  end

  // address holds between requests, so the byte stays valid after the strobe
  assign code_data  = rom[code_req.addr];
  assign xmem_rdata = xram[xmem_req.addr];

  always @(posedge clock) begin
    if (xmem_req.wr) begin
      xram[xmem_req.addr] <= xmem_req.wdata;
    end
  end
endmodule : cfes_mem_model
`default_nettype wire

// ---- testbench/cfes_sequencer_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module cfes_sequencer_tb;
  import cfes_pkg::*;
  logic              clock;
  logic              rst_n;
  logic              ce;
  cfes_code_req_type code_req;
  logic [7:0]        code_data;
  cfes_xmem_req_type xmem_req;
  logic [7:0]        xmem_rdata;
  logic [15:0]       pc_out;
  logic [15:0]       pc_hold;
  logic [7:0]        acc_out;
  logic [2:0]        state_num;
  logic              phase_two;
  logic              instr_done;
  int                miscompares;
  int                total_checks;

  cfes_sequencer dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .code_req(code_req), .code_data(code_data),
    .xmem_req(xmem_req), .xmem_rdata(xmem_rdata), .pc_out(pc_out), .acc_out(acc_out),
    .state_num(state_num), .phase_two(phase_two), .instr_done(instr_done));
  cfes_mem_model mem_u (.clock(clock), .code_req(code_req), .code_data(code_data),
    .xmem_req(xmem_req), .xmem_rdata(xmem_rdata));

  always #20 clock = ~clock;

  task automatic load_code(input logic [15:0] base, input logic [7:0] bytes_q[$]);
    for (int i = 0; i < bytes_q.size(); i++) begin
      mem_u.rom[base + 16'(i)] = bytes_q[i];
    end
  endtask : load_code

  task automatic check_x(input string nm, input logic [15:0] a, input logic [7:0] exp);
    `CHK(nm, exp, mem_u.xram[a])
  endtask : check_x

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // long enough for about five thousand machine states
  initial begin
    #400000;
    miscompares++;
    conclude();
  end

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    miscompares = 0;
    total_checks = 0;
    #1;
    // results are logged to external memory so every path leaves a trace
    load_code(16'h0000, '{8'h74, 8'haa, 8'he5, 8'hf0, 8'h90, 8'h00, 8'h15, 8'hf0,
      8'h74, 8'h5a, 8'h90, 8'h12, 8'h34, 8'hf0, 8'h74, 8'h00, 8'he0, 8'h60, 8'h02, 8'h70, 8'h02,
      8'h74, 8'h11, 8'hf5, 8'hf0, 8'h74, 8'h03, 8'hf5, 8'h30, 8'hd5, 8'h30, 8'hfd,
      8'he5, 8'h30, 8'h90, 8'h00, 8'h10, 8'hf0, 8'he5, 8'hf0, 8'h90, 8'h00, 8'h11, 8'hf0,
      8'h74, 8'h01, 8'hf5, 8'h20, 8'h10, 8'h00, 8'h02, 8'h74, 8'hee, 8'he5, 8'h20,
      8'h90, 8'h00, 8'h12, 8'hf0, 8'h74, 8'h42, 8'hf5, 8'h00, 8'he2, 8'h90, 8'h00, 8'h13, 8'hf0,
      8'h02, 8'h00, 8'h50, 8'h74, 8'h99});
    load_code(16'h0050, '{8'h74, 8'h66, 8'h21, 8'h00, 8'h74, 8'h99});
    load_code(16'h0100, '{8'h90, 8'h00, 8'h14, 8'hf0, 8'h80, 8'h7f, 8'h74, 8'h99, 8'hf0});
    // bank one pointer, indirect store and load, then a stack round trip of the accumulator
    load_code(16'h0185, '{8'h74, 8'h08, 8'hf5, 8'hd0, 8'h74, 8'h31, 8'hf5, 8'h09, 8'h74, 8'h77, 8'hf7,
      8'h74, 8'h00, 8'he7, 8'hc0, 8'he0, 8'h74, 8'h00, 8'hd0, 8'he0, 8'h90, 8'h00, 8'h16, 8'hf0, 8'h80, 8'hfe});
    mem_u.xram[16'h0042] = 8'hc3;
    repeat (7) @(posedge clock);
    @(negedge clock);
    `CHK("pc at reset", PC_RST, pc_out)
    `CHK("acc at reset", ACC_RST, acc_out)
    `CHK("state at reset", 3'h1, state_num)
    `CHK("phase at reset", 1'b0, phase_two)
    `CHK("fetch at reset", CODE_RST, code_req)
    @(posedge clock);
    rst_n <= 1'b1;
    $display("test reset values done");

    // stall during the two-cycle wide pointer load, away from any external move
    repeat (30) @(posedge clock);
    ce <= 1'b0;
    @(negedge clock);
    pc_hold = pc_out;
    repeat (5) @(posedge clock);
    @(negedge clock);
    `CHK("pc while stalled", pc_hold, pc_out)
    @(posedge clock);
    ce <= 1'b1;
    $display("test clock enable stall done");

    for (int n = 0; n < 4000 && pc_out !== 16'h019d; n++) begin
      @(posedge clock);
    end
    repeat (48) @(posedge clock);
    @(negedge clock);
    check_x("aux reset read", 16'h0015, AUX_RST);
    check_x("wide write", 16'h1234, 8'h5a);
    check_x("wide read", 16'h0011, 8'h5a);
    check_x("decrement loop", 16'h0010, 8'h00);
    check_x("bit cleared", 16'h0012, 8'h00);
    check_x("working reg read", 16'h0013, 8'hc3);
    check_x("page jump", 16'h0014, 8'h66);
    check_x("stack and indirect", 16'h0016, 8'h77);
    `CHK("acc final", 8'h77, acc_out)
    `CHK("halt loop", 12'h019, pc_out[15:4])
    $display("test program run done");
    conclude();
  end
endmodule : cfes_sequencer_tb
`default_nettype wire
